// ### verilog/aip_map.vh
// Register map, field positions, reset values and timing for the infrared serial port
`ifndef AIP_MAP_VH
`define AIP_MAP_VH

`define AIP_ADDR_PIN_CTRL    16'hFF91
`define AIP_ADDR_FRAME_FMT   16'hFF98
`define AIP_ADDR_BIT_RATE    16'hFF99
`define AIP_ADDR_SER_CTRL    16'hFF9A
`define AIP_ADDR_TX_HOLD     16'hFF9B
`define AIP_ADDR_SER_STAT    16'hFF9C
`define AIP_ADDR_RX_HOLD     16'hFF9D

`define AIP_PIN_TX_ROUTE     4

`define AIP_FMT_ASYNC_SYNC   7
`define AIP_FMT_CHAR_LEN     6
`define AIP_FMT_PAR_EN       5
`define AIP_FMT_PAR_ODD      4
`define AIP_FMT_STOP2        3
`define AIP_FMT_MULTIPROC    2

`define AIP_CTL_RX_IRQ_EN    6
`define AIP_CTL_TX_EN        5
`define AIP_CTL_RX_EN        4

`define AIP_ST_TX_EMPTY      7
`define AIP_ST_RX_FULL       6
`define AIP_ST_OVERRUN       5
`define AIP_ST_FRAMING       4
`define AIP_ST_PARITY        3
`define AIP_ST_TX_DONE       2
`define AIP_ST_MP_RX         1
`define AIP_ST_MP_TX         0

`define AIP_RST_PIN_CTRL     8'h00
`define AIP_RST_FRAME_FMT    8'h00
`define AIP_RST_BIT_RATE     8'hFF
`define AIP_RST_SER_CTRL     8'h00
`define AIP_RST_TX_HOLD      8'h00

`define AIP_TICKS_PER_BIT    32
`define AIP_LAST_TICK        5'h1F
`define AIP_IR_PULSE_TICKS   5'h06

`endif

// ### verilog/aip_top.v
// Asynchronous serial port with infrared pulse encoder and decoder
//
// Function
// - Frame format bit 7 at 0 selects asynchronous start/stop framed mode; bit 7 is only stored, so framing is always asynchronous.
// - Frame format bit 6 at 0 selects eight data bits both ways.
// - Frame format bit 5 adds parity on transmit and checks it on receive while bit 2 is 0.
// - Frame format bit 4 picks parity sense: 0 even, 1 odd.
// - Frame format bit 3 picks one or two transmitted stop bits.
// - Receiver checks only first stop bit; a 0 after it starts the next character.
// - Frame format bit 2 turns the multiprocessor function on or off.
// - Frame format bits 1:0 choose the prescaler; 00 is the undivided clock.
// - Bit rate divisor is an 8-bit read/write register setting the bit rate.
// - Control bit 6 enables receive-data and receive-error interrupt requests.
// - Control bit 5 enables the transmitter.
// - Control bit 4 enables the receiver.
// - Control bits 1:0 at 00 select the internal baud generator.
// - Holding-empty flag sets while transmit disabled or when byte moves to shifter.
// - Holding-empty clears by write 0 after reading 1, or by writing data.
// - Receive-full flag sets when an error-free byte lands in the receive holding.
// - Overrun flag sets on overflow; cleared only by write 0 after reading 1.
// - Framing flag sets on bad stop bit; cleared by write 0 after reading 1.
// - Transmit-complete sets while disabled or when last bit leaves with holding empty.
// - Writing 1 to a clearable status flag does nothing.
// - Encoder sends a 3/16 bit high pulse for each 0, nothing for 1.
// - Decoder yields 0 on a pulse within a bit period, 1 otherwise.
// - Receive-data request follows receive-full; error request follows error flags.
// - Bit time is 32 times 2 to the n times divisor plus one clocks.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "aip_map.vh"

module aip_top (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        infrared_rx_pin,
    output reg         infrared_tx_pin,
    output reg         serial_tx_pin,
    output reg         rx_data_irq,
    output reg         rx_error_irq
);

    localparam [1:0] TX_IDLE  = 2'b01;
    localparam [1:0] TX_SHIFT = 2'b10;
    localparam [1:0] RX_IDLE  = 2'b01;
    localparam [1:0] RX_BITS  = 2'b10;

    // Parity over the active data bits; odd sense inverts
    function par_bit;
        input [7:0] data;
        input       seven;
        input       odd;
        begin
            par_bit = ^(seven ? {1'b0, data[6:0]} : data) ^ odd;
        end
    endfunction

    // Index of the bit after the data field
    function [3:0] extra_idx;
        input seven;
        begin
            extra_idx = seven ? 4'h8 : 4'h9;
        end
    endfunction

    reg  [7:0] pin_ctrl_q;
    reg  [7:0] frame_fmt_q;
    reg  [7:0] bit_rate_q;
    reg  [7:0] ser_ctrl_q;
    reg  [7:0] tx_hold_q;
    reg  [7:0] rx_hold_q;
    reg        tx_empty_q;
    reg        rx_full_q;
    reg        overrun_q;
    reg        framing_q;
    reg        parity_q;
    reg        tx_done_q;
    reg        mp_rx_q;
    reg        mp_tx_q;
    reg  [7:0] armed_q;

    wire seven     = frame_fmt_q[`AIP_FMT_CHAR_LEN];
    wire par_en    = frame_fmt_q[`AIP_FMT_PAR_EN];
    wire par_odd   = frame_fmt_q[`AIP_FMT_PAR_ODD];
    wire two_stop  = frame_fmt_q[`AIP_FMT_STOP2];
    wire mp_en     = frame_fmt_q[`AIP_FMT_MULTIPROC];
    wire has_extra = par_en | mp_en;
    wire tx_en     = ser_ctrl_q[`AIP_CTL_TX_EN];
    wire rx_en     = ser_ctrl_q[`AIP_CTL_RX_EN];

    wire wr_stat = reg_wr && (reg_addr == `AIP_ADDR_SER_STAT);
    wire wr_txh  = reg_wr && (reg_addr == `AIP_ADDR_TX_HOLD);

    // Clear only a flag seen as 1 and written 0; writing 1 is ignored
    wire [7:0] clr = wr_stat ? (armed_q & ~reg_wdata) : 8'h00;

    // Baud generator: prescale 2^n then divisor+1 gives 32 ticks per bit
    // Only the internal generator exists, so control bits 1:0 are stored only
    reg  [2:0] pre_cnt_q;
    reg  [7:0] baud_cnt_q;
    reg  [2:0] pre_max;
    always @* begin
        case (frame_fmt_q[1:0])
            2'b00:   pre_max = 3'h0;
            2'b01:   pre_max = 3'h1;
            2'b10:   pre_max = 3'h3;
            default: pre_max = 3'h7;
        endcase
    end
    wire pre_tick = (pre_cnt_q == pre_max);
    wire tick     = pre_tick && (baud_cnt_q == bit_rate_q);

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_q  <= 3'h0;
            baud_cnt_q <= 8'h00;
        end else begin
            pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
            if (tick)
                baud_cnt_q <= 8'h00;
            else if (pre_tick)
                baud_cnt_q <= baud_cnt_q + 8'h01;
        end
    end

    // Transmitter
    reg  [1:0]  tx_st_q;
    reg  [11:0] tx_sh_q;
    reg  [3:0]  tx_left_q;
    reg  [4:0]  tx_ph_q;
    reg  [11:0] tx_frame;
    reg  [3:0]  tx_len;
    integer     i;

    always @* begin
        tx_frame = 12'hFFF;
        tx_frame[0] = 1'b0;
        for (i = 0; i < 8; i = i + 1)
            if (i < 7 || !seven)
                tx_frame[i + 1] = tx_hold_q[i];
        if (has_extra)
            tx_frame[extra_idx(seven)] = mp_en ? mp_tx_q
                                               : par_bit(tx_hold_q, seven, par_odd);
        tx_len = extra_idx(seven) + {3'h0, has_extra} + 4'h1 + {3'h0, two_stop};
    end

    wire tx_load    = (tx_st_q == TX_IDLE) && tx_en && !tx_empty_q && tick;
    wire tx_bit_end = (tx_st_q == TX_SHIFT) && tick && (tx_ph_q == `AIP_LAST_TICK);
    wire tx_last    = tx_bit_end && (tx_left_q == 4'h1);
    wire tx_chain   = tx_last && !tx_empty_q;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_q   <= TX_IDLE;
            tx_sh_q   <= 12'hFFF;
            tx_left_q <= 4'h0;
            tx_ph_q   <= 5'h00;
        end else if (!tx_en) begin
            tx_st_q   <= TX_IDLE;
            tx_sh_q   <= 12'hFFF;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_st_q   <= TX_SHIFT;
                        tx_sh_q   <= tx_frame;
                        tx_left_q <= tx_len;
                        tx_ph_q   <= 5'h00;
                    end
                end
                TX_SHIFT: begin
                    if (tick)
                        tx_ph_q <= tx_ph_q + 5'h01;
                    if (tx_chain) begin
                        tx_sh_q   <= tx_frame;
                        tx_left_q <= tx_len;
                    end else if (tx_last) begin
                        tx_st_q   <= TX_IDLE;
                        tx_sh_q   <= 12'hFFF;
                    end else if (tx_bit_end) begin
                        tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                        tx_left_q <= tx_left_q - 4'h1;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    wire tx_move = tx_load || tx_chain;

    // Receiver: three-stage sync, level accepted once stages two and three agree
    reg  rx_s1_q;
    reg  rx_s2_q;
    reg  rx_s3_q;
    reg  ir_q;
    reg  ir_prev_q;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_q   <= 1'b0;
            rx_s2_q   <= 1'b0;
            rx_s3_q   <= 1'b0;
            ir_q      <= 1'b0;
            ir_prev_q <= 1'b0;
        end else begin
            rx_s1_q   <= infrared_rx_pin;
            rx_s2_q   <= rx_s1_q;
            rx_s3_q   <= rx_s2_q;
            if (rx_s2_q == rx_s3_q)
                ir_q <= rx_s3_q;
            ir_prev_q <= ir_q;
        end
    end
    wire pulse_rise = ir_q && !ir_prev_q;

    reg  [1:0]  rx_st_q;
    reg  [11:0] rx_sh_q;
    reg  [3:0]  rx_idx_q;
    reg  [4:0]  rx_ph_q;
    reg         rx_seen_q;

    wire [3:0] stop_idx  = extra_idx(seven) + {3'h0, has_extra};
    wire       win_end   = (rx_st_q == RX_BITS) && tick && (rx_ph_q == `AIP_LAST_TICK);
    wire       rx_bit    = ~(rx_seen_q | ir_q);
    // Pulse in the stop slot: bad stop and start of the next character
    wire       stop_hit  = (rx_st_q == RX_BITS) && (rx_idx_q == stop_idx) && pulse_rise;
    wire       stop_ok   = win_end && (rx_idx_q == stop_idx) && rx_bit;
    wire       rx_done   = stop_hit || stop_ok;
    wire [7:0] rx_data   = seven ? {1'b0, rx_sh_q[7:1]} : rx_sh_q[8:1];
    wire       rx_extra  = rx_sh_q[extra_idx(seven)];
    wire       par_bad   = par_en && !mp_en &&
                           (rx_extra != par_bit(rx_data, seven, par_odd));

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_q   <= RX_IDLE;
            rx_sh_q   <= 12'h000;
            rx_idx_q  <= 4'h0;
            rx_ph_q   <= 5'h00;
            rx_seen_q <= 1'b0;
        end else if (!rx_en) begin
            rx_st_q   <= RX_IDLE;
        end else begin
            case (rx_st_q)
                RX_IDLE: begin
                    if (pulse_rise) begin
                        rx_st_q   <= RX_BITS;
                        rx_idx_q  <= 4'h0;
                        // Window shuts before the next pulse edge can leak in
                        rx_ph_q   <= 5'h01;
                        rx_seen_q <= 1'b1;
                    end
                end
                RX_BITS: begin
                    if (tick)
                        rx_ph_q <= rx_ph_q + 5'h01;
                    if (stop_hit) begin
                        rx_idx_q  <= 4'h0;
                        rx_ph_q   <= 5'h01;
                        rx_seen_q <= 1'b1;
                    end else if (win_end) begin
                        rx_sh_q[rx_idx_q] <= rx_bit;
                        rx_seen_q <= 1'b0;
                        if (rx_idx_q == stop_idx)
                            rx_st_q <= RX_IDLE;
                        else
                            rx_idx_q <= rx_idx_q + 4'h1;
                    end else if (ir_q) begin
                        rx_seen_q <= 1'b1;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    wire rx_good = rx_done && !stop_hit && !par_bad;
    wire set_ovr = rx_good && rx_full_q;
    wire set_rdf = rx_good && !rx_full_q;

    // Registers and status; every hardware set wins over a software clear
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_ctrl_q  <= `AIP_RST_PIN_CTRL;
            frame_fmt_q <= `AIP_RST_FRAME_FMT;
            bit_rate_q  <= `AIP_RST_BIT_RATE;
            ser_ctrl_q  <= `AIP_RST_SER_CTRL;
            tx_hold_q   <= `AIP_RST_TX_HOLD;
            rx_hold_q   <= 8'h00;
            tx_empty_q  <= 1'b1;
            rx_full_q   <= 1'b0;
            overrun_q   <= 1'b0;
            framing_q   <= 1'b0;
            parity_q    <= 1'b0;
            tx_done_q   <= 1'b1;
            mp_rx_q     <= 1'b0;
            mp_tx_q     <= 1'b0;
            armed_q     <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `AIP_ADDR_PIN_CTRL)
                pin_ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == `AIP_ADDR_FRAME_FMT)
                frame_fmt_q <= reg_wdata;
            if (reg_wr && reg_addr == `AIP_ADDR_BIT_RATE)
                bit_rate_q <= reg_wdata;
            if (reg_wr && reg_addr == `AIP_ADDR_SER_CTRL)
                ser_ctrl_q <= reg_wdata;
            if (wr_txh)
                tx_hold_q <= reg_wdata;
            if (wr_stat)
                mp_tx_q <= reg_wdata[`AIP_ST_MP_TX];
            if (reg_rd && reg_addr == `AIP_ADDR_SER_STAT)
                armed_q <= {tx_empty_q, rx_full_q, overrun_q, framing_q, parity_q, 3'b000};
            else if (wr_stat)
                armed_q <= 8'h00;

            if (!tx_en || tx_move)
                tx_empty_q <= 1'b1;
            else if (wr_txh || clr[`AIP_ST_TX_EMPTY])
                tx_empty_q <= 1'b0;

            if (!tx_en || (tx_last && tx_empty_q))
                tx_done_q <= 1'b1;
            else if (wr_txh || clr[`AIP_ST_TX_EMPTY])
                tx_done_q <= 1'b0;

            if (set_rdf) begin
                rx_full_q <= 1'b1;
                rx_hold_q <= rx_data;
                mp_rx_q   <= mp_en & rx_extra;
            end else if (clr[`AIP_ST_RX_FULL]) begin
                rx_full_q <= 1'b0;
            end
            if (set_ovr)
                overrun_q <= 1'b1;
            else if (clr[`AIP_ST_OVERRUN])
                overrun_q <= 1'b0;
            if (stop_hit)
                framing_q <= 1'b1;
            else if (clr[`AIP_ST_FRAMING])
                framing_q <= 1'b0;
            if (rx_done && !stop_hit && par_bad)
                parity_q <= 1'b1;
            else if (clr[`AIP_ST_PARITY])
                parity_q <= 1'b0;
        end
    end

    // Read data valid only in the cycle after the strobe
    reg [7:0] rd_mux;
    always @* begin
        case (reg_addr)
            `AIP_ADDR_PIN_CTRL:  rd_mux = pin_ctrl_q;
            `AIP_ADDR_FRAME_FMT: rd_mux = frame_fmt_q;
            `AIP_ADDR_BIT_RATE:  rd_mux = bit_rate_q;
            `AIP_ADDR_SER_CTRL:  rd_mux = ser_ctrl_q;
            `AIP_ADDR_TX_HOLD:   rd_mux = tx_hold_q;
            `AIP_ADDR_SER_STAT:  rd_mux = {tx_empty_q, rx_full_q, overrun_q, framing_q,
                                           parity_q, tx_done_q, mp_rx_q, mp_tx_q};
            `AIP_ADDR_RX_HOLD:   rd_mux = rx_hold_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    // Pin driving; IR output idles low, wired serial pin idles high
    wire line_bit = (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata       <= 8'h00;
            infrared_tx_pin <= 1'b0;
            serial_tx_pin   <= 1'b1;
            rx_data_irq     <= 1'b0;
            rx_error_irq    <= 1'b0;
        end else begin
            reg_rdata       <= reg_rd ? rd_mux : 8'h00;
            infrared_tx_pin <= !line_bit && (tx_ph_q < `AIP_IR_PULSE_TICKS);
            // Unrouted pin holds idle; enable order is software's job
            serial_tx_pin   <= pin_ctrl_q[`AIP_PIN_TX_ROUTE] ? line_bit : 1'b1;
            rx_data_irq     <= ser_ctrl_q[`AIP_CTL_RX_IRQ_EN] && rx_full_q;
            rx_error_irq    <= ser_ctrl_q[`AIP_CTL_RX_IRQ_EN] &&
                               (overrun_q || framing_q || parity_q);
        end
    end

endmodule

`default_nettype wire

// ### testbench/aip_top_asserts.sv
// Concurrent checks on the infrared serial port pins and register bus
`timescale 1ns/1ps
`default_nettype none
module aip_top_asserts (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        infrared_rx_pin,
    input wire logic        infrared_tx_pin,
    input wire logic        serial_tx_pin,
    input wire logic        rx_data_irq,
    input wire logic        rx_error_irq
);
    logic [7:0] pin_q, fmt_q, rate_q, ctl_q;
    logic [2:0] off_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Shadow registers fed from the bus alone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_q <= 8'h00;
            fmt_q <= 8'h00;
            rate_q <= 8'hFF;
            ctl_q <= 8'h00;
            off_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == 16'hFF91) pin_q <= reg_wdata;
            if (reg_wr && reg_addr == 16'hFF98) fmt_q <= reg_wdata;
            if (reg_wr && reg_addr == 16'hFF99) rate_q <= reg_wdata;
            if (reg_wr && reg_addr == 16'hFF9A) ctl_q <= reg_wdata;
            // Saturates so a long idle stretch never wraps back
            off_q <= ctl_q[5] ? 3'h0 : (off_q == 3'h7 ? off_q : off_q + 3'h1);
        end
    end
    sequence pulse_s;
        infrared_tx_pin [*6];
    endsequence
    format_readback_a: assert property (
        reg_rd && reg_addr == 16'hFF98 |=> reg_rdata == $past(fmt_q))
        else $error("frame format readback wrong");
    rate_readback_a: assert property (
        reg_rd && reg_addr == 16'hFF99 |=> reg_rdata == $past(rate_q))
        else $error("divisor readback wrong");
    control_readback_a: assert property (
        reg_rd && reg_addr == 16'hFF9A |=> reg_rdata == $past(ctl_q))
        else $error("control readback wrong");
    tx_off_flags_a: assert property (
        reg_rd && reg_addr == 16'hFF9C && !ctl_q[5] && !$past(ctl_q[5])
        |=> reg_rdata[7] && reg_rdata[2]) else $error("empty flags not set");
    ir_pulse_a: assert property (
        $rose(infrared_tx_pin) |-> pulse_s) else $error("infrared pulse too short");
    ir_zero_bit_a: assert property (
        $rose(infrared_tx_pin) && pin_q[4] |-> !serial_tx_pin)
        else $error("pulse on a one bit");
    ir_quiet_a: assert property (
        off_q == 3'h7 |-> !infrared_tx_pin) else $error("pulse while disabled");
    pin_unrouted_a: assert property (
        !pin_q[4] && !$past(pin_q[4]) |-> serial_tx_pin) else $error("pin not idle");
    data_irq_mask_a: assert property (
        rx_data_irq |-> $past(ctl_q[6])) else $error("data request unmasked");
    error_irq_mask_a: assert property (
        rx_error_irq |-> $past(ctl_q[6])) else $error("error request unmasked");
endmodule
bind aip_top aip_top_asserts i_aip_top_asserts (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .infrared_rx_pin(infrared_rx_pin),
    .infrared_tx_pin(infrared_tx_pin), .serial_tx_pin(serial_tx_pin),
    .rx_data_irq(rx_data_irq), .rx_error_irq(rx_error_irq));
`default_nettype wire

// ### testbench/aip_ir_station.sv
// Infrared station model: sends pulse frames and decodes the port pulses
`timescale 1ns/1ps
`default_nettype none
module aip_ir_station (
    input  wire logic sys_clk,
    input  wire logic infrared_tx_pin,
    output var logic  ir_line
);
    int          bit_clks = 32;
    int          n_bits = 10;
    int          bad_width = 0;
    logic [11:0] got[$];
    initial ir_line = 1'b0;
    // LSB first; a 0 is a 3/16 bit pulse, a 1 a quiet window
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            ir_line <= !bits[i];
            repeat (bit_clks * 3 / 16) @(posedge sys_clk);
            ir_line <= 1'b0;
            repeat (bit_clks - bit_clks * 3 / 16) @(posedge sys_clk);
        end
    endtask
    // Windows open at the start pulse, so a skewed pulse shows as a bad width
    always begin
        logic [11:0] f;
        int          hi;
        if (infrared_tx_pin !== 1'b1) begin
            @(posedge sys_clk);
        end else begin
            f = 12'hFFF;
            for (int i = 0; i < n_bits; i++) begin
                hi = 0;
                repeat (bit_clks) begin
                    hi += int'(infrared_tx_pin);
                    @(posedge sys_clk);
                end
                f[i] = (hi == 0);
                if (hi != 0 && hi != bit_clks * 3 / 16) bad_width++;
            end
            got.push_back(f);
        end
    end
endmodule
`default_nettype wire

// ### testbench/aip_top_tb.sv
// Self-checking bench: register tasks and infrared frames both ways
`timescale 1ns/1ps
`default_nettype none
module aip_top_tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata, rd;
    logic        infrared_rx_pin, infrared_tx_pin, serial_tx_pin;
    logic        rx_data_irq, rx_error_irq;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [15:0] ra[7] = '{16'hFF91, 16'hFF98, 16'hFF99, 16'hFF9A, 16'hFF9B, 16'hFF9C, 16'hFF90};
    logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h84, 8'h00};
    logic [23:0] tx[5] = '{24'h000055, 24'h0800A6, 24'h200001, 24'h3001C3, 24'h010039};
    always #10 sys_clk = ~sys_clk;
    aip_top i_aip_top (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .infrared_rx_pin(infrared_rx_pin),
        .infrared_tx_pin(infrared_tx_pin), .serial_tx_pin(serial_tx_pin),
        .rx_data_irq(rx_data_irq), .rx_error_irq(rx_error_irq));
    aip_ir_station i_aip_ir_station (
        .sys_clk(sys_clk), .infrared_tx_pin(infrared_tx_pin), .ir_line(infrared_rx_pin));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    // The trailing edge keeps two strobes from landing in one time step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic rchk(input string w, input logic [15:0] a, input logic [7:0] e);
        rd8(a, rd);
        chk(w, {4'h0, e}, {4'h0, rd});
    endtask
    task automatic set_fmt(input logic [7:0] f, input logic [7:0] dv);
        wr(16'hFF98, f);
        wr(16'hFF99, dv);
        i_aip_ir_station.bit_clks = 32 * (1 << int'(f[1:0])) * (int'(dv) + 1);
        i_aip_ir_station.n_bits = 10 + int'(f[5]) + int'(f[3]);
        i_aip_ir_station.got.delete();
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 3000 && i_aip_ir_station.got.size() < n; k++) @(posedge sys_clk);
    endtask
    task automatic waitq(input bit err);
        for (int k = 0; k < 100; k++) begin
            if ((err ? rx_error_irq : rx_data_irq) === 1'b1) break;
            @(posedge sys_clk);
        end
    endtask
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] f);
        if (f[5]) return {2'b11, ^d ^ f[4], d, 1'b0};
        return {3'b111, d, 1'b0};
    endfunction
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++) rchk("reset value", ra[i], rv[i]);
        wr(16'hFF9C, 8'hFE);
        rchk("status", 16'hFF9C, 8'h84);
        wr(16'hFF98, 8'hFC);
        wr(16'hFF99, 8'h5A);
        wr(16'hFF9A, 8'h53);
        rchk("format", 16'hFF98, 8'hFC);
        rchk("divisor", 16'hFF99, 8'h5A);
        rchk("control", 16'hFF9A, 8'h53);
        $display("test registers done");
        wr(16'hFF91, 8'h10);
        wr(16'hFF9A, 8'h20);
        foreach (tx[i]) begin
            set_fmt(tx[i][23:16], tx[i][15:8]);
            wr(16'hFF9B, tx[i][7:0]);
            wait_frames(1);
            chk("frame", frame(tx[i][7:0], tx[i][23:16]), i_aip_ir_station.got[0]);
            rchk("status", 16'hFF9C, 8'h84);
        end
        set_fmt(8'h00, 8'h00);
        wr(16'hFF9B, 8'h0F);
        rd = 8'h00;
        for (int k = 0; k < 40 && rd[7] !== 1'b1; k++) rd8(16'hFF9C, rd);
        wr(16'hFF9B, 8'hF0);
        rchk("status", 16'hFF9C, 8'h00);
        wait_frames(2);
        chk("frame", frame(8'h0F, 8'h00), i_aip_ir_station.got[0]);
        chk("frame", frame(8'hF0, 8'h00), i_aip_ir_station.got[1]);
        $display("test transmit done");
        i_aip_ir_station.send(frame(8'h3C, 8'h00), 10);
        rchk("status", 16'hFF9C, 8'h84);
        wr(16'hFF9A, 8'h70);
        i_aip_ir_station.send(frame(8'h3C, 8'h00), 10);
        waitq(1'b0);
        chk("data irq", 12'h001, {11'h000, rx_data_irq});
        rchk("status", 16'hFF9C, 8'hC4);
        i_aip_ir_station.send(frame(8'hA5, 8'h00), 10);
        waitq(1'b1);
        chk("error irq", 12'h001, {11'h000, rx_error_irq});
        rchk("holding", 16'hFF9D, 8'h3C);
        rchk("status", 16'hFF9C, 8'hE4);
        wr(16'hFF9C, 8'h84);
        rchk("status", 16'hFF9C, 8'h84);
        wr(16'hFF9A, 8'h30);
        i_aip_ir_station.send(frame(8'h3C, 8'h00) ^ 12'h200, 10);
        repeat (400) @(posedge sys_clk);
        rd8(16'hFF9C, rd);
        chk("framing", 12'h001, {11'h000, rd[4]});
        chk("error irq", 12'h000, {11'h000, rx_error_irq});
        wr(16'hFF9A, 8'h70);
        waitq(1'b1);
        chk("error irq", 12'h001, {11'h000, rx_error_irq});
        wr(16'hFF9C, 8'h84);
        rchk("status", 16'hFF9C, 8'h84);
        set_fmt(8'h20, 8'h00);
        i_aip_ir_station.send(frame(8'h01, 8'h20) ^ 12'h200, 11);
        waitq(1'b1);
        rd8(16'hFF9C, rd);
        chk("parity", 12'h001, {11'h000, rd[3]});
        chk("parity drop", 12'h000, {11'h000, rd[6]});
        $display("test receive done");
        chk("pulse width", 12'h000, 12'(i_aip_ir_station.bad_width));
        end_sim();
    end
endmodule
`default_nettype wire
